//--- hdl/eb_defs.svh
// Constants for the two-channel eight-bit event timer
`ifndef EB_DEFS_SVH
`define EB_DEFS_SVH
`define EB_OFF_COUNT 8'h00
`define EB_OFF_CMP 8'h04
`define EB_OFF_CSEL 8'h08
`define EB_OFF_MODE 8'h0c
`define EB_CH_BIT 4
`define EB_MAP_TOP_BIT 5
`define EB_MODE_RUN 7
`define EB_MODE_PWM 6
`define EB_MODE_FFSET 3
`define EB_MODE_FFCLR 2
`define EB_MODE_INV 1
`define EB_MODE_OE 0
`define EB_MODE_RESET 1'b0
`define EB_CMP_RESET 8'h00
`define EB_CSEL_RESET 3'h0
`define EB_CSEL_FALL 3'h0
`define EB_CSEL_RISE 3'h1
`define EB_CSEL_FIRST_INT 3'h2
`define EB_PRE_W 10
`define EB_CNT_ZERO 8'h00
`define EB_CNT_TOP 8'hff
`define EB_RESP_OKAY 2'b00
`define EB_RESP_SLVERR 2'b10
`endif

//--- hdl/eb_pkg.sv
// Types shared by the event timer files
package eb_pkg;
    typedef enum logic [1:0] {
        EB_REG_COUNT,
        EB_REG_CMP,
        EB_REG_CSEL,
        EB_REG_MODE
    } eb_reg_e;
endpackage

//--- hdl/eb_tick_gen.sv
// Count clock source for one timer channel
`timescale 1ns/10ps
`default_nettype none
`include "eb_defs.svh"
module eb_tick_gen
    import eb_pkg::*;
#(
    parameter int PRE_W = `EB_PRE_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [2:0] clkSel,
    input wire logic eventIn,
    output logic tick
);
    logic [PRE_W-1:0] prescale;
    logic eventPrev;

    // Divide by 4 to the power (select - 2)
    function automatic logic [PRE_W-1:0] preMask(input logic [2:0] sel);
        logic [PRE_W-1:0] m;
        m = '0;
        for (int i = 0; i < PRE_W; i++) begin
            if (i < 2 * (int'(sel) - int'(`EB_CSEL_FIRST_INT))) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Free running, so a start lands anywhere within a count clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prescale <= '0;
        end else if (ce) begin
            prescale <= prescale + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            eventPrev <= 1'b0;
        end else if (ce) begin
            eventPrev <= eventIn;
        end
    end

    always_comb begin
        case (clkSel)
            `EB_CSEL_FALL: tick = eventPrev && !eventIn;
            `EB_CSEL_RISE: tick = !eventPrev && eventIn;
            default: tick = (prescale & preMask(clkSel)) == preMask(clkSel);
        endcase
    end
endmodule
`default_nettype wire

//--- hdl/eb_event_timer.sv
// Two-channel eight-bit timer and event counter with AXI4-Lite registers
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "eb_defs.svh"
module eb_event_timer
    import eb_pkg::*;
#(
    parameter int NCH = 2,
    parameter int PRE_W = `EB_PRE_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NCH-1:0] eventInputPin,
    output logic [NCH-1:0] timerOutputPin,
    output logic [NCH-1:0] matchIrq
);
    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel state

    logic [7:0] upCounter [NCH];
    logic [7:0] compareValue [NCH];
    logic [7:0] activeCompare [NCH];
    logic [2:0] countClockSelect [NCH];
    logic runBit [NCH];
    logic pwmBit [NCH];
    logic invBit [NCH];
    logic oeBit [NCH];
    logic outFlipFlop [NCH];
    logic pwmActive [NCH];
    logic [NCH-1:0] tick;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic logic addrMapped(input logic [31:0] a);
        return (a[31:`EB_MAP_TOP_BIT] == '0) && (a[1:0] == 2'b00)
            && (int'(a[`EB_CH_BIT]) < NCH);
    endfunction

    function automatic eb_reg_e addrReg(input logic [31:0] a);
        return eb_reg_e'(a[3:2]);
    endfunction

    function automatic int addrCh(input logic [31:0] a);
        return int'(a[`EB_CH_BIT]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Write channels

    logic [31:0] wrAddr;
    logic [7:0] wrData;
    logic wrLowLane;
    logic wrFire;
    logic wrMapped;
    eb_reg_e wrReg;
    int wrCh;

    // Each channel is taken on its own; the write happens once both are held
    assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wrMapped = addrMapped(wrAddr);
    assign wrReg = addrReg(wrAddr);
    assign wrCh = addrCh(wrAddr);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            wrAddr <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wrAddr <= s_axi_awaddr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_wready <= 1'b1;
            wrData <= 8'h00;
            wrLowLane <= 1'b0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wrData <= s_axi_wdata[7:0];
                wrLowLane <= s_axi_wstrb[0];
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EB_RESP_OKAY;
        end else if (ce) begin
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? `EB_RESP_OKAY : `EB_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel

    function automatic logic [7:0] readReg(input logic [31:0] a);
        logic [7:0] v;
        int c;
        v = 8'h00;
        c = addrCh(a);
        if (addrMapped(a)) begin
            case (addrReg(a))
                EB_REG_COUNT: v = upCounter[c];
                EB_REG_CMP: v = compareValue[c];
                EB_REG_CSEL: v = {5'h00, countClockSelect[c]};
                EB_REG_MODE: v = {runBit[c], pwmBit[c], 4'h0, invBit[c], oeBit[c]};
                default: v = 8'h00;
            endcase
        end
        return v;
    endfunction

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `EB_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, readReg(s_axi_araddr)};
                s_axi_rresp <= addrMapped(s_axi_araddr) ? `EB_RESP_OKAY : `EB_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer channels, each with its own state and pins

    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        logic hit;
        logic modeWr;
        logic cmpWr;
        logic matchNow;
        logic overflow;
        logic [7:0] cntInc;

        assign hit = wrFire && wrMapped && wrLowLane && (wrCh == ch);
        assign modeWr = hit && (wrReg == EB_REG_MODE);
        assign cmpWr = hit && (wrReg == EB_REG_CMP);
        assign cntInc = upCounter[ch] + 8'h01;
        assign overflow = pwmBit[ch] && (upCounter[ch] == `EB_CNT_TOP);
        // PWM match looks one count ahead so the width is exactly N counts
        assign matchNow = pwmBit[ch] ? (!overflow && cntInc == activeCompare[ch])
                                     : (upCounter[ch] == activeCompare[ch]);

        eb_tick_gen #(
            .PRE_W(PRE_W)
        ) u_tick (
            .clk(clk),
            .rstn(rstn),
            .ce(ce),
            .clkSel(countClockSelect[ch]),
            .eventIn(eventInputPin[ch]),
            .tick(tick[ch])
        );

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                runBit[ch] <= `EB_MODE_RESET;
                pwmBit[ch] <= `EB_MODE_RESET;
                invBit[ch] <= `EB_MODE_RESET;
                oeBit[ch] <= `EB_MODE_RESET;
            end else if (ce && modeWr) begin
                runBit[ch] <= wrData[`EB_MODE_RUN];
                pwmBit[ch] <= wrData[`EB_MODE_PWM];
                invBit[ch] <= wrData[`EB_MODE_INV];
                oeBit[ch] <= wrData[`EB_MODE_OE];
            end
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                countClockSelect[ch] <= `EB_CSEL_RESET;
            end else if (ce && hit && wrReg == EB_REG_CSEL) begin
                countClockSelect[ch] <= wrData[2:0];
            end
        end

        // Outside PWM the new value takes effect at once
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                compareValue[ch] <= `EB_CMP_RESET;
                activeCompare[ch] <= `EB_CMP_RESET;
            end else if (ce) begin
                if (cmpWr) begin
                    compareValue[ch] <= wrData;
                end
                if (cmpWr && !pwmBit[ch]) begin
                    activeCompare[ch] <= wrData;
                end else if (runBit[ch] && tick[ch] && overflow) begin
                    activeCompare[ch] <= compareValue[ch];
                end
            end
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                upCounter[ch] <= `EB_CNT_ZERO;
            end else if (ce) begin
                if (!runBit[ch]) begin
                    upCounter[ch] <= `EB_CNT_ZERO;
                end else if (tick[ch]) begin
                    if (pwmBit[ch]) begin
                        upCounter[ch] <= cntInc;
                    end else if (matchNow) begin
                        upCounter[ch] <= `EB_CNT_ZERO;
                    end else begin
                        upCounter[ch] <= cntInc;
                    end
                end
            end
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                matchIrq[ch] <= 1'b0;
            end else if (ce) begin
                matchIrq[ch] <= runBit[ch] && tick[ch] && matchNow;
            end
        end

        // Set and clear codes act only on a write with the PWM bit clear; 11 is ignored
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                outFlipFlop[ch] <= 1'b0;
            end else if (ce) begin
                if (modeWr && !wrData[`EB_MODE_PWM]
                    && (wrData[`EB_MODE_FFSET] != wrData[`EB_MODE_FFCLR])) begin
                    outFlipFlop[ch] <= wrData[`EB_MODE_FFSET];
                end else if (runBit[ch] && tick[ch] && !pwmBit[ch] && matchNow
                             && invBit[ch]) begin
                    outFlipFlop[ch] <= !outFlipFlop[ch];
                end
            end
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                pwmActive[ch] <= 1'b0;
            end else if (ce) begin
                if (!runBit[ch] || !pwmBit[ch]) begin
                    pwmActive[ch] <= 1'b0;
                end else if (tick[ch] && overflow) begin
                    // A zero width never goes active
                    pwmActive[ch] <= (compareValue[ch] != `EB_CNT_ZERO);
                end else if (tick[ch] && matchNow) begin
                    pwmActive[ch] <= 1'b0;
                end
            end
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                timerOutputPin[ch] <= 1'b0;
            end else if (ce) begin
                if (!oeBit[ch]) begin
                    timerOutputPin[ch] <= 1'b0;
                end else if (pwmBit[ch]) begin
                    timerOutputPin[ch] <= pwmActive[ch] ^ invBit[ch];
                end else begin
                    timerOutputPin[ch] <= outFlipFlop[ch];
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/eb_event_timer_sva.sv
// Port checker for the event timer, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module eb_event_timer_sva
    import eb_pkg::*;
#(
    parameter int NCH = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NCH-1:0] timerOutputPin,
    input wire logic [NCH-1:0] matchIrq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    // Mode shadow lags the register a clock; the repeats below absorb that
    logic [4:0] awAddr;
    logic [7:0] wByte;
    logic [15:0] mode;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awAddr <= 5'h00;
            wByte <= 8'h00;
            mode <= 16'h0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                awAddr <= s_axi_awaddr[4:0];
            if (s_axi_wvalid && s_axi_wready)
                wByte <= s_axi_wdata[7:0];
            if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0 && awAddr[3:0] == 4'hc)
                mode[{awAddr[4], 3'h0} +: 8] <= wByte;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_out_off: assert property ((!mode[0]) [*2] |-> !timerOutputPin[0])
        else $error("disabled output not low");
    a_pwm_idle: assert property ((mode[6] && !mode[7] && mode[0]) [*3] |-> timerOutputPin[0] == mode[1])
        else $error("stopped pwm output not inactive");
    a_stop_quiet: assert property ((!mode[7]) [*3] |-> !matchIrq[0])
        else $error("match request while stopped");
    a_ch1_quiet: assert property ((!mode[15]) [*3] |-> !matchIrq[1])
        else $error("second channel request while stopped");
endmodule
bind eb_event_timer eb_event_timer_sva #(.NCH(NCH)) sva_u (
    .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timerOutputPin(timerOutputPin), .matchIrq(matchIrq)
);
`default_nettype wire

//--- dv/eb_pulse_src.sv
// Far-side model: event pulse source and timer pin load
`timescale 1ns/10ps
`default_nettype none
module eb_pulse_src (
    input wire logic clk,
    input wire logic [1:0] timerOutputPin,
    output logic [1:0] eventInputPin
);
    initial eventInputPin = 2'h0;
    // Levels held four clocks so every edge is seen apart
    task drive(input int c, input logic v);
        @(posedge clk);
        eventInputPin[c] <= v;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- dv/test_eb_event_timer.sv
// Self-checking bench for the two-channel event timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
    compares++; \
    if ((a) !== (b)) begin \
        failures++; \
        $display("BAD %0t got %0h expected %0h", $time, (a), (b)); \
    end \
end
module test_eb_event_timer;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic ce = 1'h1;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, evPin, outPin, irq;
    logic [31:0] s_axi_rdata;
    int failures = 0, compares = 0, cyc = 0;
    int irqCnt [2] = '{0, 0};
    always #20 clk = ~clk;
    // Hang guard: every scenario fits well inside this many clocks
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq[0] === 1'h1)
            irqCnt[0] <= irqCnt[0] + 1;
        if (irq[1] === 1'h1)
            irqCnt[1] <= irqCnt[1] + 1;
        if (cyc == 20000) begin
            failures++;
            finish_test();
        end
    end
    eb_event_timer dut_u (
        .clk(clk), .rstn(rstn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .eventInputPin(evPin), .timerOutputPin(outPin), .matchIrq(irq)
    );
    eb_pulse_src pulse_u (.clk(clk), .timerOutputPin(outPin), .eventInputPin(evPin));
    ////////////////////////////////////////////////////////////////////////////////
    task finish_test;
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        `CHK(s_axi_bresp, er)
        s_axi_bready <= 1'h0;
        @(posedge clk);
    endtask
    task rc(input logic [31:0] a, input logic [7:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        `CHK(s_axi_rdata, {24'h000000, e})
        `CHK(s_axi_rresp, er)
        s_axi_rready <= 1'h0;
        @(posedge clk);
    endtask
    task waitLvl(input int c, input logic v);
        while (outPin[c] !== v)
            @(posedge clk);
    endtask
    task width(input int c, input logic v, output int w);
        int t0;
        waitLvl(c, !v);
        waitLvl(c, v);
        t0 = cyc;
        waitLvl(c, !v);
        w = cyc - t0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        rc(32'h0c, 8'h00, 2'h0);
        rc(32'h14, 8'h00, 2'h0);
        wr(32'h0c, 8'h0b, 2'h0);
        wr(32'h1c, 8'h07, 2'h0);
        rc(32'h0c, 8'h03, 2'h0);
        rc(32'h1c, 8'h03, 2'h0);
        `CHK(outPin, 2'h1)
        wr(32'h08, 8'h05, 2'h0);
        rc(32'h18, 8'h00, 2'h0);
        rc(32'h08, 8'h05, 2'h0);
        wr(32'h00, 8'h55, 2'h0);
        rc(32'h00, 8'h00, 2'h0);
        wr(32'h40, 8'h01, 2'h2);
        rc(32'h40, 8'h00, 2'h2);
        rc(32'h05, 8'h00, 2'h2);
    endtask
    task t_square(input logic [2:0] sel);
        int w;
        int e;
        e = 6 << (2 * (int'(sel) - 2));
        wr(32'h08, {5'h00, sel}, 2'h0);
        wr(32'h04, 8'h05, 2'h0);
        wr(32'h0c, 8'h07, 2'h0);
        `CHK(outPin[0], 1'h0)
        wr(32'h0c, 8'h87, 2'h0);
        width(0, 1'h1, w);
        `CHK(w, e)
        width(0, 1'h0, w);
        `CHK(w, e)
        wr(32'h0c, 8'h07, 2'h0);
        rc(32'h00, 8'h00, 2'h0);
        `CHK(irqCnt[1], 0)
    endtask
    task t_event;
        wr(32'h1c, 8'h00, 2'h0);
        wr(32'h18, 8'h01, 2'h0);
        wr(32'h14, 8'h02, 2'h0);
        wr(32'h1c, 8'h80, 2'h0);
        pulse_u.drive(1, 1'h1);
        rc(32'h10, 8'h01, 2'h0);
        pulse_u.drive(1, 1'h0);
        rc(32'h10, 8'h01, 2'h0);
        pulse_u.drive(1, 1'h1);
        rc(32'h10, 8'h02, 2'h0);
        pulse_u.drive(1, 1'h0);
        pulse_u.drive(1, 1'h1);
        rc(32'h10, 8'h00, 2'h0);
        `CHK(irqCnt[1], 1)
        wr(32'h1c, 8'h00, 2'h0);
        wr(32'h18, 8'h00, 2'h0);
        wr(32'h1c, 8'h80, 2'h0);
        pulse_u.drive(1, 1'h0);
        rc(32'h10, 8'h01, 2'h0);
        pulse_u.drive(1, 1'h1);
        rc(32'h10, 8'h01, 2'h0);
        wr(32'h1c, 8'h00, 2'h0);
    endtask
    task t_pwm;
        int w;
        int t0;
        wr(32'h0c, 8'h05, 2'h0);
        wr(32'h08, 8'h02, 2'h0);
        wr(32'h04, 8'h40, 2'h0);
        wr(32'h0c, 8'h41, 2'h0);
        wr(32'h0c, 8'hc1, 2'h0);
        width(0, 1'h1, w);
        `CHK(w, 64)
        width(0, 1'h0, w);
        `CHK(w, 192)
        waitLvl(0, 1'h1);
        t0 = cyc;
        wr(32'h04, 8'h80, 2'h0);
        rc(32'h04, 8'h80, 2'h0);
        waitLvl(0, 1'h0);
        `CHK(cyc - t0, 64)
        width(0, 1'h1, w);
        `CHK(w, 128)
        wr(32'h0c, 8'h41, 2'h0);
        rc(32'h00, 8'h00, 2'h0);
        `CHK(outPin[0], 1'h0)
        wr(32'h0c, 8'h43, 2'h0);
        wr(32'h0c, 8'hc3, 2'h0);
        `CHK(outPin[0], 1'h1)
        width(0, 1'h0, w);
        `CHK(w, 128)
        wr(32'h0c, 8'h43, 2'h0);
        rc(32'h04, 8'h80, 2'h0);
        `CHK(outPin[0], 1'h1)
        wr(32'h0c, 8'h49, 2'h0);
        wr(32'h0c, 8'h01, 2'h0);
        `CHK(outPin[0], 1'h0)
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        t_regs();
        for (int s = 2; s < 5; s++)
            t_square(s[2:0]);
        t_event();
        t_pwm();
        finish_test();
    end
endmodule
`default_nettype wire
